// >>> core/amf_pkg.sv
// shared constants, types and frame helpers of the framing port
package amf_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int BIT_RATE_HZ = 1_562_500;
	localparam int SAMPLES_PER_BIT = 8;
	localparam logic [3:0] DIV_LAST = 4'(CLK_HZ / (BIT_RATE_HZ * SAMPLES_PER_BIT) - 1);
	localparam int DATA_W = 8;
	localparam int FRAME_W = 13;
	localparam logic [7:0] CCR_RESET = 8'h00;
	localparam int CCR_MODE = 3;
	localparam int CCR_PAR_EN = 5;
	localparam int CCR_PAR_EVEN = 6;
	localparam int CCR_STOP2 = 7;
	localparam logic [3:0] IDLE_BLOCK_BITS = 4'ha;
	localparam logic [3:0] MARK_IDLE_BITS = 4'hb;
	localparam logic [6:0] IDLE_BLOCK_TICKS = 7'(int'(IDLE_BLOCK_BITS) * SAMPLES_PER_BIT);
	localparam logic [2:0] START_LOW_LAST = 3'h3;
	localparam logic [2:0] PH_START_OK = 3'h4;
	localparam logic [2:0] PH_VOTE_A = 3'h4;
	localparam logic [2:0] PH_VOTE_B = 3'h5;
	localparam logic [2:0] PH_VOTE_C = 3'h6;
	localparam logic [2:0] PH_BIT_END = 3'h7;

	typedef enum logic [0:0] {RX_HUNT = 1'b0, RX_BITS = 1'b1} amf_rx_state_t;
	typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} amf_tx_state_t;

	// data bits per character, one to eight
	function automatic logic [3:0] amf_char_len(input logic [7:0] ccr);
		return {1'b0, ccr[2:0]} + 4'h1;
	endfunction : amf_char_len

	// bits after the start bit up to the first stop bit
	function automatic logic [3:0] amf_rx_bits(input logic [7:0] ccr);
		return amf_char_len(ccr) + {3'h0, ccr[CCR_MODE]} + {3'h0, ccr[CCR_PAR_EN]} + 4'h1;
	endfunction : amf_rx_bits

	// {length, bits lsb first}: start, data, address, parity, stop
	function automatic logic [16:0] amf_frame(input logic [7:0] d, input logic [7:0] ccr,
		input logic mk);
		logic [12:0] v;
		logic [3:0] n;
		logic [3:0] p;
		logic par;
		v = '1;
		n = amf_char_len(ccr);
		par = ~ccr[CCR_PAR_EVEN];
		v[0] = 1'b0;
		p = 4'h1;
		for (int i = 0; i < 8; i++)
		begin
			if (i < int'(n))
			begin
				v[p] = d[i];
				par = par ^ d[i];
				p = p + 4'h1;
			end
		end
		if (ccr[CCR_MODE])
		begin
			v[p] = mk;
			par = par ^ mk;
			p = p + 4'h1;
		end
		if (ccr[CCR_PAR_EN])
		begin
			v[p] = par;
			p = p + 4'h1;
		end
		p = p + 4'h1 + {3'h0, ccr[CCR_STOP2]};
		return {p, v};
	endfunction : amf_frame

	// {address bit, parity error, stop error, data} of a received frame
	function automatic logic [10:0] amf_rx_fields(input logic [12:0] b, input logic [7:0] ccr);
		logic [7:0] d;
		logic [3:0] n;
		logic [3:0] p;
		logic par;
		logic a;
		logic pe;
		d = '0;
		n = amf_char_len(ccr);
		par = ~ccr[CCR_PAR_EVEN];
		a = 1'b0;
		pe = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (i < int'(n))
			begin
				d[i] = b[i];
				par = par ^ b[i];
			end
		end
		p = n;
		if (ccr[CCR_MODE])
		begin
			a = b[p];
			par = par ^ b[p];
			p = p + 4'h1;
		end
		if (ccr[CCR_PAR_EN])
		begin
			pe = par ^ b[p];
			p = p + 4'h1;
		end
		return {a, pe, ~b[p], d};
	endfunction : amf_rx_fields
endpackage : amf_pkg

// >>> core/amf_link_if.sv
// serial line wires between the port and a remote processor
`timescale 1ns/100ps
interface amf_link_if;
	logic port_txd;
	logic remote_txd;
	modport port (output port_txd, input remote_txd);
	modport remote (output remote_txd, input port_txd);
endinterface : amf_link_if

// >>> core/amf_pipe_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module amf_pipe_buf #(
	parameter int W = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	import amf_pkg::*;
	logic [W-1:0] mem_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] count_ff;
	logic push;
	logic pop;

	assign in_ready_o = (count_ff != 2'h2);
	assign out_valid_o = (count_ff != 2'h0);
	assign out_data_o = mem_ff[rd_ptr_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge clock_i)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data_i;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= ~wr_ptr_ff;
			if (pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			if (push && !pop)
				count_ff <= count_ff + 2'h1;
			else if (pop && !push)
				count_ff <= count_ff - 2'h1;
		end
	end
endmodule : amf_pipe_buf

// >>> core/amf_port.sv
// local end of the framing port: transmitter, receiver and wake-up logic
`timescale 1ns/100ps
// Operation
// - frame: start, data, address, parity, stop bits
// - line carries plain non-return-to-zero levels
// - control bits two to zero set length
// - control bit five enables parity
// - control bit six: odd zero, even one
// - control bit seven: one or two stops
// - control bit three: idle-line or address-bit
// - dormant receiver sets no flags except address
// - hardware never changes the dormant bit
// - address frame wakes port, requests interrupt
// - address flag shows address or data frame
// - ten idle bit times start a block
// - remote idles ten bits before address in idle mode
// - shifter load copies mark to shadow, clears
// - idle mode mark sends eleven idle bits
// - software sets mark, dummy, then address
// - holding buffer and mark free after load
// - address bit carries the shadow mark value
// - eight sample ticks per bit
// - majority vote of samples four to six
// - full flag set on load, cleared by read
module amf_port (
	input wire logic clock_i,
	input wire logic rst_i,
	amf_link_if.port link,
	input wire logic ccr_wr_i,
	input wire logic [amf_pkg::DATA_W-1:0] ccr_wdata_i,
	output logic [amf_pkg::DATA_W-1:0] frame_format_control_o,
	input wire logic rx_dormant_i,
	input wire logic rx_break_irq_enable_i,
	input wire logic tx_mark_set_i,
	output logic tx_block_mark_o,
	output logic tx_mark_shadow_o,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic [amf_pkg::DATA_W-1:0] tx_data_i,
	output logic tx_empty_o,
	input wire logic rx_read_i,
	output logic [amf_pkg::DATA_W-1:0] rx_holding_buf_o,
	output logic rx_full_flag_o,
	output logic rx_address_flag_o,
	output logic rx_parity_err_o,
	output logic rx_frame_err_o,
	output logic rx_interrupt_o
);
	import amf_pkg::*;

	logic [3:0] div_ff;
	logic tick;
	logic [7:0] ccr_ff;
	logic idle_mode;
	logic hold_valid;
	logic hold_ready;
	logic [DATA_W-1:0] hold_data;
	logic tx_load;
	logic mark_ff;
	logic shadow_ff;
	amf_tx_state_t tx_st_ff;
	logic [FRAME_W-1:0] tx_shifter_ff;
	logic [3:0] tx_left_ff;
	logic [2:0] tx_ph_ff;
	logic [16:0] tx_frame;
	logic [3:0] nxt_len;
	logic [FRAME_W-1:0] nxt_vec;
	logic rxd;
	amf_rx_state_t rx_st_ff;
	logic [2:0] rx_ph_ff;
	logic [2:0] nxt_ph;
	logic [2:0] rx_low_ff;
	logic [1:0] rx_votes_ff;
	logic [3:0] rx_idx_ff;
	logic [FRAME_W-1:0] rx_shifter_ff;
	logic rx_done_ff;
	logic [6:0] idle_cnt_ff;
	logic gap_ff;
	logic [10:0] fields;
	logic is_addr;
	logic accept;
	logic [DATA_W-1:0] rx_data_ff;
	logic rx_full_ff;
	logic rx_addr_ff;
	logic rx_perr_ff;
	logic rx_ferr_ff;

	// ***********************************
	// sample tick and format control
	// ***********************************
	assign tick = (div_ff == DIV_LAST);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			div_ff <= 4'h0;
		else if (tick)
			div_ff <= 4'h0;
		else
			div_ff <= div_ff + 4'h1;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			ccr_ff <= CCR_RESET;
		else if (ccr_wr_i)
			ccr_ff <= ccr_wdata_i;
	end

	assign frame_format_control_o = ccr_ff;
	assign idle_mode = ~ccr_ff[CCR_MODE];

	// ***********************************
	// transmitter
	// ***********************************
	amf_pipe_buf #(.W(DATA_W)) u_hold (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_valid_i(tx_valid_i),
		.in_ready_o(tx_ready_o),
		.in_data_i(tx_data_i),
		.out_valid_o(hold_valid),
		.out_ready_i(hold_ready),
		.out_data_o(hold_data)
	);

	// loads only on a tick so the start bit spans eight whole ticks
	assign hold_ready = (tx_st_ff == TX_IDLE) & tick;
	assign tx_load = hold_valid & hold_ready;
	assign tx_frame = amf_frame(hold_data, ccr_ff, mark_ff);

	always_comb
	begin
		if (idle_mode && mark_ff)
		begin
			nxt_len = MARK_IDLE_BITS;
			nxt_vec = '1;
		end
		else
		begin
			nxt_len = tx_frame[16:13];
			nxt_vec = tx_frame[12:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			mark_ff <= 1'b0;
		else if (tx_mark_set_i)
			mark_ff <= 1'b1;
		else if (tx_load)
			mark_ff <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			shadow_ff <= 1'b0;
		else if (tx_load)
			shadow_ff <= mark_ff;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_st_ff <= TX_IDLE;
			tx_shifter_ff <= '1;
			tx_left_ff <= 4'h0;
			tx_ph_ff <= 3'h0;
		end
		else
		begin
			case (tx_st_ff)
				TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_shifter_ff <= nxt_vec;
						tx_left_ff <= nxt_len;
						tx_ph_ff <= 3'h0;
						tx_st_ff <= TX_SHIFT;
					end
				end
				default:
				begin
					if (tick)
					begin
						tx_ph_ff <= tx_ph_ff + 3'h1;
						if (tx_ph_ff == PH_BIT_END)
						begin
							tx_shifter_ff <= {1'b1, tx_shifter_ff[FRAME_W-1:1]};
							tx_left_ff <= tx_left_ff - 4'h1;
							if (tx_left_ff == 4'h1)
								tx_st_ff <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign link.port_txd = tx_shifter_ff[0];
	assign tx_block_mark_o = mark_ff;
	assign tx_mark_shadow_o = shadow_ff;
	assign tx_empty_o = (tx_st_ff == TX_IDLE) & ~hold_valid;

	// ***********************************
	// receiver
	// ***********************************
	assign rxd = link.remote_txd;
	assign nxt_ph = rx_ph_ff + 3'h1;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_st_ff <= RX_HUNT;
			rx_ph_ff <= 3'h0;
			rx_low_ff <= 3'h0;
			rx_votes_ff <= 2'h0;
			rx_idx_ff <= 4'h0;
			rx_shifter_ff <= '1;
			rx_done_ff <= 1'b0;
		end
		else
		begin
			rx_done_ff <= 1'b0;
			case (rx_st_ff)
				RX_HUNT:
				begin
					if (tick && rxd)
						rx_low_ff <= 3'h0;
					else if (tick && rx_low_ff == START_LOW_LAST)
					begin
						rx_st_ff <= RX_BITS;
						rx_ph_ff <= PH_START_OK;
						rx_idx_ff <= 4'h0;
						rx_votes_ff <= 2'h0;
						rx_low_ff <= 3'h0;
					end
					else if (tick)
						rx_low_ff <= rx_low_ff + 3'h1;
				end
				default:
				begin
					if (tick)
					begin
						rx_ph_ff <= nxt_ph;
						if (nxt_ph == PH_VOTE_A || nxt_ph == PH_VOTE_B)
							rx_votes_ff <= rx_votes_ff + {1'b0, rxd};
						else if (nxt_ph == PH_VOTE_C)
						begin
							rx_shifter_ff[rx_idx_ff] <= rx_votes_ff[1] |
								(rx_votes_ff[0] & rxd);
							rx_votes_ff <= 2'h0;
							// index zero holds the start bit vote
							if (rx_idx_ff == amf_rx_bits(ccr_ff))
							begin
								rx_st_ff <= RX_HUNT;
								rx_done_ff <= 1'b1;
							end
							else
								rx_idx_ff <= rx_idx_ff + 4'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			idle_cnt_ff <= 7'h0;
		else if (rx_st_ff == RX_BITS || (tick && !rxd))
			idle_cnt_ff <= 7'h0;
		else if (tick && idle_cnt_ff != IDLE_BLOCK_TICKS)
			idle_cnt_ff <= idle_cnt_ff + 7'h1;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			gap_ff <= 1'b0;
		else if (rx_st_ff == RX_HUNT && tick && !rxd && rx_low_ff == 3'h0)
			gap_ff <= (idle_cnt_ff == IDLE_BLOCK_TICKS);
	end

	assign fields = amf_rx_fields({1'b1, rx_shifter_ff[FRAME_W-1:1]}, ccr_ff);
	assign is_addr = idle_mode ? gap_ff : fields[10];
	assign accept = rx_done_ff & (~rx_dormant_i | is_addr);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_data_ff <= '0;
			rx_addr_ff <= 1'b0;
			rx_perr_ff <= 1'b0;
			rx_ferr_ff <= 1'b0;
		end
		else if (accept)
		begin
			rx_data_ff <= fields[7:0];
			rx_addr_ff <= is_addr;
			rx_perr_ff <= fields[9];
			rx_ferr_ff <= fields[8];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rx_full_ff <= 1'b0;
		else if (accept)
			rx_full_ff <= 1'b1;
		else if (rx_read_i)
			rx_full_ff <= 1'b0;
	end

	assign rx_holding_buf_o = rx_data_ff;
	assign rx_full_flag_o = rx_full_ff;
	assign rx_address_flag_o = rx_addr_ff;
	assign rx_parity_err_o = rx_perr_ff;
	assign rx_frame_err_o = rx_ferr_ff;
	assign rx_interrupt_o = rx_full_ff & rx_break_irq_enable_i;
endmodule : amf_port

// >>> core/amf_remote.sv
// remote processor end of the framing link
`timescale 1ns/100ps
module amf_remote (
	input wire logic clock_i,
	input wire logic rst_i,
	amf_link_if.remote link,
	input wire logic [amf_pkg::DATA_W-1:0] fmt_i,
	input wire logic tx_valid_i,
	input wire logic tx_addr_i,
	input wire logic [amf_pkg::DATA_W-1:0] tx_data_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [amf_pkg::DATA_W-1:0] rx_data_o,
	output logic rx_addr_o,
	output logic rx_parity_err_o,
	output logic rx_frame_err_o
);
	import amf_pkg::*;

	logic [3:0] div_ff;
	logic tick;
	logic need_gap;
	logic gap_done_ff;
	logic tx_go;
	logic [16:0] frame;
	amf_tx_state_t tx_st_ff;
	logic [FRAME_W-1:0] tx_sh_ff;
	logic [3:0] tx_left_ff;
	logic [2:0] tx_ph_ff;
	logic rxd;
	amf_rx_state_t rx_st_ff;
	logic [2:0] rx_ph_ff;
	logic [3:0] rx_idx_ff;
	logic [FRAME_W:0] rx_sh_ff;
	logic rx_done_ff;
	logic [6:0] idle_cnt_ff;
	logic gap_ff;
	logic [10:0] fields;

	// ***********************************
	// tick and transmitter
	// ***********************************
	assign tick = (div_ff == DIV_LAST);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			div_ff <= 4'h0;
		else if (tick)
			div_ff <= 4'h0;
		else
			div_ff <= div_ff + 4'h1;
	end

	assign need_gap = tx_addr_i & ~fmt_i[CCR_MODE] & ~gap_done_ff;
	assign tx_ready_o = (tx_st_ff == TX_IDLE) & ~need_gap;
	assign tx_go = (tx_st_ff == TX_IDLE) & tx_valid_i;
	assign frame = amf_frame(tx_data_i, fmt_i, tx_addr_i);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_st_ff <= TX_IDLE;
			tx_sh_ff <= '1;
			tx_left_ff <= 4'h0;
			tx_ph_ff <= 3'h0;
			gap_done_ff <= 1'b0;
		end
		else if (tx_go)
		begin
			tx_st_ff <= TX_SHIFT;
			tx_ph_ff <= 3'h0;
			gap_done_ff <= need_gap;
			tx_sh_ff <= need_gap ? '1 : frame[12:0];
			tx_left_ff <= need_gap ? IDLE_BLOCK_BITS : frame[16:13];
		end
		else if (tx_st_ff == TX_SHIFT && tick)
		begin
			tx_ph_ff <= tx_ph_ff + 3'h1;
			if (tx_ph_ff == PH_BIT_END)
			begin
				tx_sh_ff <= {1'b1, tx_sh_ff[FRAME_W-1:1]};
				tx_left_ff <= tx_left_ff - 4'h1;
				if (tx_left_ff == 4'h1)
					tx_st_ff <= TX_IDLE;
			end
		end
	end

	assign link.remote_txd = tx_sh_ff[0];

	// ***********************************
	// receiver, mid-bit sampling
	// ***********************************
	assign rxd = link.port_txd;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_st_ff <= RX_HUNT;
			rx_ph_ff <= 3'h0;
			rx_idx_ff <= 4'h0;
			rx_sh_ff <= '1;
			rx_done_ff <= 1'b0;
		end
		else
		begin
			rx_done_ff <= 1'b0;
			if (rx_st_ff == RX_HUNT && tick && !rxd)
			begin
				rx_st_ff <= RX_BITS;
				rx_ph_ff <= 3'h1;
				rx_idx_ff <= 4'h0;
			end
			else if (rx_st_ff == RX_BITS && tick)
			begin
				rx_ph_ff <= rx_ph_ff + 3'h1;
				if (rx_ph_ff + 3'h1 == PH_VOTE_B)
				begin
					rx_sh_ff[rx_idx_ff] <= rxd;
					if (rx_idx_ff == 4'h0 && rxd)
						rx_st_ff <= RX_HUNT;
					else if (rx_idx_ff == amf_rx_bits(fmt_i))
					begin
						rx_st_ff <= RX_HUNT;
						rx_done_ff <= 1'b1;
					end
					else
						rx_idx_ff <= rx_idx_ff + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			idle_cnt_ff <= 7'h0;
		else if (rx_st_ff == RX_BITS || (tick && !rxd))
			idle_cnt_ff <= 7'h0;
		else if (tick && idle_cnt_ff != IDLE_BLOCK_TICKS)
			idle_cnt_ff <= idle_cnt_ff + 7'h1;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			gap_ff <= 1'b0;
		else if (rx_st_ff == RX_HUNT && tick && !rxd)
			gap_ff <= (idle_cnt_ff == IDLE_BLOCK_TICKS);
	end

	assign fields = amf_rx_fields(rx_sh_ff[FRAME_W:1], fmt_i);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_valid_o <= 1'b0;
			rx_data_o <= '0;
			rx_addr_o <= 1'b0;
			rx_parity_err_o <= 1'b0;
			rx_frame_err_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= rx_done_ff;
			if (rx_done_ff)
			begin
				rx_data_o <= fields[7:0];
				rx_addr_o <= fmt_i[CCR_MODE] ? fields[10] : gap_ff;
				rx_parity_err_o <= fields[9];
				rx_frame_err_o <= fields[8];
			end
		end
	end
endmodule : amf_remote

// >>> tb/amf_link_chk.sv
// concurrent checks on the serial link and the port user side
`timescale 1ns/100ps
module amf_link_chk (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic port_txd,
	input wire logic remote_txd,
	input wire logic tx_mark_set_i,
	input wire logic tx_block_mark_o,
	input wire logic tx_mark_shadow_o,
	input wire logic tx_empty_o,
	input wire logic rx_dormant_i,
	input wire logic rx_full_flag_o,
	input wire logic rx_address_flag_o,
	input wire logic rx_break_irq_enable_i,
	input wire logic rx_interrupt_o
);
	import amf_pkg::*;
	localparam int BIT_CLKS = (int'(DIV_LAST) + 1) * SAMPLES_PER_BIT;
	logic txd_ff;
	logic [15:0] run_ff;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// ************************************************************
	// length of the current line level run
	// ************************************************************
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			txd_ff <= 1'b1;
			run_ff <= 16'hffff;
		end
		else
		begin
			txd_ff <= port_txd;
			if (port_txd != txd_ff)
				run_ff <= 16'h0001;
			else if (run_ff != 16'hffff)
				run_ff <= run_ff + 16'h0001;
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	property p_idle_high;
		tx_empty_o |-> port_txd;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low while empty");
	property p_reset_idle;
		$fell(rst_i) |-> port_txd && remote_txd;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("line low after reset");
	property p_low_run;
		port_txd && !txd_ff |-> run_ff >= 16'(BIT_CLKS) && int'(run_ff) % BIT_CLKS <= 9;
	endproperty
	a_low_run: assert property (p_low_run) else $error("low run not whole bits");
	property p_high_run;
		!port_txd && txd_ff |-> run_ff >= 16'(BIT_CLKS);
	endproperty
	a_high_run: assert property (p_high_run) else $error("high run too short");
	property p_dormant;
		$rose(rx_full_flag_o) && $past(rx_dormant_i) |-> rx_address_flag_o;
	endproperty
	a_dormant: assert property (p_dormant) else $error("dormant full on data");
	property p_irq;
		rx_interrupt_o == (rx_full_flag_o && rx_break_irq_enable_i);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt mismatch");
	property p_mark_set;
		tx_mark_set_i |=> tx_block_mark_o;
	endproperty
	a_mark_set: assert property (p_mark_set) else $error("mark not set");
	property p_mark_move;
		$fell(tx_block_mark_o) |-> tx_mark_shadow_o;
	endproperty
	a_mark_move: assert property (p_mark_move) else $error("mark lost");
	property p_shadow_src;
		$rose(tx_mark_shadow_o) |-> $past(tx_block_mark_o);
	endproperty
	a_shadow_src: assert property (p_shadow_src) else $error("shadow without mark");
endmodule : amf_link_chk

// >>> tb/tb_async_serial_multiproc_framing.sv
// self-checking bench: port and remote joined by the link
`timescale 1ns/100ps
module tb_async_serial_multiproc_framing;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic ccr_wr = 1'b0, dorm = 1'b0, irq_en = 1'b1, mk_set = 1'b0, tx_v = 1'b0, rd_s = 1'b0;
	logic r_v = 1'b0, r_a = 1'b0;
	logic [7:0] ccr_d = 8'h00, tx_d = 8'h00, r_d = 8'h00;
	logic [7:0] ccr_o, rx_buf, rr_data, got_d;
	logic mk_o, sh_o, tx_rdy, tx_emp, full, adf, perr, ferr, irq, r_rdy, rr_v, rr_a, rr_pe, rr_fe;
	logic got_a;
	int n_fail = 0, compares = 0, cyc = 0, r_cnt = 0;
	logic [7:0] fmts [5] = '{8'h07, 8'h64, 8'h23, 8'hac, 8'h08};
	amf_link_if link ();
	amf_port u_amf_port (.clock_i(clock_i), .rst_i(rst_i), .link(link), .ccr_wr_i(ccr_wr),
		.ccr_wdata_i(ccr_d), .frame_format_control_o(ccr_o), .rx_dormant_i(dorm),
		.rx_break_irq_enable_i(irq_en), .tx_mark_set_i(mk_set), .tx_block_mark_o(mk_o),
		.tx_mark_shadow_o(sh_o), .tx_valid_i(tx_v), .tx_ready_o(tx_rdy), .tx_data_i(tx_d),
		.tx_empty_o(tx_emp), .rx_read_i(rd_s), .rx_holding_buf_o(rx_buf), .rx_full_flag_o(full),
		.rx_address_flag_o(adf), .rx_parity_err_o(perr), .rx_frame_err_o(ferr),
		.rx_interrupt_o(irq));
	amf_remote u_amf_remote (.clock_i(clock_i), .rst_i(rst_i), .link(link), .fmt_i(ccr_d),
		.tx_valid_i(r_v), .tx_addr_i(r_a), .tx_data_i(r_d), .tx_ready_o(r_rdy), .rx_valid_o(rr_v),
		.rx_data_o(rr_data), .rx_addr_o(rr_a), .rx_parity_err_o(rr_pe), .rx_frame_err_o(rr_fe));
	amf_link_chk u_amf_link_chk (.clock_i(clock_i), .rst_i(rst_i), .port_txd(link.port_txd),
		.remote_txd(link.remote_txd), .tx_mark_set_i(mk_set), .tx_block_mark_o(mk_o),
		.tx_mark_shadow_o(sh_o), .tx_empty_o(tx_emp), .rx_dormant_i(dorm),
		.rx_full_flag_o(full), .rx_address_flag_o(adf), .rx_break_irq_enable_i(irq_en),
		.rx_interrupt_o(irq));
	// ************************************************************
	// clock, timeout, remote receive capture
	// ************************************************************
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		if (rr_v === 1'b1)
		begin
			r_cnt++;
			got_d = rr_data;
			got_a = rr_a;
		end
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			conclude();
		end
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic conclude();
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (e !== g)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick
	function automatic logic [12:0] fr(input logic [7:0] d, c, input logic mk, output int n);
		logic [12:0] v;
		logic par;
		v = '0;
		par = ~c[6];
		n = 1;
		for (int i = 0; i <= int'(c[2:0]); i++)
		begin
			v[n] = d[i];
			par ^= d[i];
			n++;
		end
		if (c[3])
		begin
			v[n] = mk;
			par ^= mk;
			n++;
		end
		if (c[5])
		begin
			v[n] = par;
			n++;
		end
		v[n] = 1'b1;
		n++;
		if (c[7])
		begin
			v[n] = 1'b1;
			n++;
		end
		return v;
	endfunction : fr
	task automatic pulse(input int s);
		@(posedge clock_i);
		case (s)
			0: ccr_wr <= 1'b1;
			1: mk_set <= 1'b1;
			default: rd_s <= 1'b1;
		endcase
		@(posedge clock_i);
		ccr_wr <= 1'b0;
		mk_set <= 1'b0;
		rd_s <= 1'b0;
		@(posedge clock_i);
	endtask : pulse
	task automatic psend(input logic [7:0] d);
		@(posedge clock_i);
		tx_v <= 1'b1;
		tx_d <= d;
		do @(posedge clock_i); while (tx_rdy !== 1'b1);
		tx_v <= 1'b0;
	endtask : psend
	task automatic rsend(input logic [7:0] d, input logic a);
		@(posedge clock_i);
		r_v <= 1'b1;
		r_d <= d;
		r_a <= a;
		do @(posedge clock_i); while (r_rdy !== 1'b1);
		r_v <= 1'b0;
	endtask : rsend
	task automatic wait_for(input int w);
		int k;
		k = 0;
		while (((w < 0) ? full !== 1'b1 : (w > 0) ? r_cnt < w : link.port_txd !== 1'b0)
			&& k < 3000)
		begin
			@(posedge clock_i);
			k++;
		end
		if (k >= 3000)
			chk("wait limit", 16'h0000, 16'h0001);
		if (w == 0)
			chk("mark gap", 16'h0001, 16'(k >= 870 && k <= 900));
	endtask : wait_for
	task automatic capture(input logic [12:0] e, input int n);
		logic [12:0] g;
		g = '0;
		while (link.port_txd !== 1'b0)
			@(posedge clock_i);
		tick(40);
		for (int i = 0; i < n; i++)
		begin
			g[i] = link.port_txd;
			tick(80);
		end
		chk("wire frame", 16'(e), 16'(g));
	endtask : capture
	task automatic rx_chk(input logic [7:0] d, input logic a, input logic [7:0] m);
		wait_for(-1);
		chk("rx data", 16'(d & m), 16'(rx_buf));
		chk("rx flags", {13'h0, a, 2'h0}, {13'h0, adf, perr, ferr});
		chk("irq", 16'h0001, 16'(irq));
		pulse(2);
		chk("full clear", 16'h0000, 16'(full));
	endtask : rx_chk
	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		logic [12:0] e;
		logic [7:0] c;
		logic [7:0] m;
		int n;
		tick(4);
		rst_i <= 1'b0;
		tick(1);
		chk("reset", 16'h0030, {ccr_o, 2'h0, tx_rdy, tx_emp, full, mk_o, sh_o, irq});
		for (int i = 0; i < 5; i++)
		begin
			c = fmts[i];
			m = 8'hff >> (3'h7 - c[2:0]);
			ccr_d <= c;
			pulse(0);
			chk("format", 16'(c), 16'(ccr_o));
			if (c[3])
				pulse(1);
			e = fr(8'ha5, c, c[3], n);
			psend(8'ha5);
			capture(e, n);
			wait_for(i + 1);
			chk("remote rx", {7'h0, c[3] & got_a, got_d & m}, {7'h0, c[3], 8'ha5 & m});
			chk("remote err", 16'h0000, {14'h0, rr_pe, rr_fe});
			rsend(8'h5a, 1'b1);
			rx_chk(8'h5a, 1'b1, m);
			rsend(8'hc3, 1'b0);
			rx_chk(8'hc3, 1'b0, m);
		end
		ccr_d <= 8'h0f;
		pulse(0);
		dorm <= 1'b1;
		irq_en <= 1'b0;
		rsend(8'h11, 1'b0);
		tick(1400);
		chk("dormant", 16'h0000, 16'(full));
		rsend(8'h22, 1'b1);
		wait_for(-1);
		chk("wake", 16'h0122, {7'h0, adf, rx_buf});
		chk("irq off", 16'h0000, 16'(irq));
		pulse(2);
		dorm <= 1'b0;
		irq_en <= 1'b1;
		ccr_d <= 8'h07;
		pulse(0);
		pulse(1);
		chk("mark", 16'h0001, 16'(mk_o));
		n = r_cnt;
		psend(8'hff);
		psend(8'h3c);
		wait_for(0);
		wait_for(n + 1);
		chk("after mark", 16'h003c, 16'(got_d));
		tick(200);
		conclude();
	end
endmodule : tb_async_serial_multiproc_framing
